// ---- smcg_top.v ----
// sleep mode selection, unit clock enables and port reset tri-state
//
// Contract
// - six software selectable sleep modes
// - idle halts cpu only
// - power-down stops oscillator until interrupt/reset
// - power-save keeps asynchronous timer running
// - adc noise reduction keeps timer and adc
// - standby keeps oscillator running only
// - extended standby keeps oscillator and timer
// - power-on reset tri-states all port pins asynchronously; pin reset does it synchronously
// - long reset pin low forces reset
`timescale 1ns/1ns
`default_nettype none
`include "smcg_consts.vh"

module smcg_top #(
    parameter integer PORT_W  = `SMCG_PORT_W,      // general purpose pins
    parameter integer MIN_CYC = (`SMCG_RST_MIN_NS + `SMCG_CLK_NS - 1) / `SMCG_CLK_NS
) (
    input  wire                   clk,
    input  wire                   rstn,            // power-on reset, active low
    input  wire                   ext_rstn,        // reset pin, active low
    input  wire                   sleep_en,        // software allows sleep
    input  wire [`SMCG_MODE_W-1:0] sleep_mode,     // software mode field
    input  wire                   sleep_req,       // cpu executes sleep, pulse
    input  wire                   wake_irq,        // any enabled interrupt, level
    input  wire [PORT_W-1:0]      port_oe_req,     // port direction from port logic
    output reg  [`SMCG_EN_W-1:0]  clk_en_r,        // unit clock enables
    output reg                    cpu_run_r,       // cpu may execute
    output reg                    asleep_r,        // block is sleeping
    output reg  [`SMCG_MODE_W-1:0] mode_r,         // latched sleep mode
    output reg  [PORT_W-1:0]      port_oe_r,       // port output enables
    output reg                    sys_rst_r        // reset to rest of chip
);
    // ****************************************
    // states
    // ****************************************
    // run: cpu clocked and executing, sleep requests are looked at
    // sleep: the mode vector drives the enables until a wake is seen
    // wake: one cycle with every clock on and the cpu still held,
    // so gated units settle before the first instruction runs
    localparam [1:0] ST_RUN   = 2'b00;             // executing
    localparam [1:0] ST_SLEEP = 2'b01;             // sleeping
    localparam [1:0] ST_WAKE  = 2'b10;             // clocks back, cpu held

    reg [1:0] state_r;                             // current state
    reg [1:0] state_nxt;                           // next state
    wire      ext_rst;                             // filtered pin reset
    reg       wake_s1_r;                           // wake sync first stage
    reg       wake_s2_r;                           // wake sync second stage

    // enable vector kept in each mode
    // bit order follows the unit list: cpu, sram, timers, spi, irq,
    // async timer, adc, oscillator; a set bit keeps that unit clocked
    // deep modes drop the irq bit, so wake relies on the synchronised
    // wake input, which sits on the always-on clock of this block
    // reserved codes return all ones so a stray request never gates
    function [`SMCG_EN_W-1:0] mode_en;
        input [`SMCG_MODE_W-1:0] m;
        begin
            mode_en = `SMCG_EN_NONE;
            case (m)
                `SMCG_MODE_IDLE: begin
                    mode_en = `SMCG_EN_ALL;
                    mode_en[`SMCG_EN_CPU] = 1'b0;
                end
                `SMCG_MODE_ADCNR: begin
                    mode_en[`SMCG_EN_OSC]  = 1'b1;
                    mode_en[`SMCG_EN_ATMR] = 1'b1;
                    mode_en[`SMCG_EN_ADC]  = 1'b1;
                    mode_en[`SMCG_EN_IRQ]  = 1'b1;
                end
                `SMCG_MODE_PDOWN: begin
                    mode_en = `SMCG_EN_NONE;
                end
                `SMCG_MODE_PSAVE: begin
                    mode_en[`SMCG_EN_ATMR] = 1'b1;
                end
                `SMCG_MODE_STBY: begin
                    mode_en[`SMCG_EN_OSC] = 1'b1;
                end
                `SMCG_MODE_XSTBY: begin
                    mode_en[`SMCG_EN_OSC]  = 1'b1;
                    mode_en[`SMCG_EN_ATMR] = 1'b1;
                end
                default: begin
                    mode_en = `SMCG_EN_ALL;        // reserved codes do not sleep
                end
            endcase
        end
    endfunction

    // legal mode check
    function mode_ok;
        input [`SMCG_MODE_W-1:0] m;
        begin
            mode_ok = (m == `SMCG_MODE_IDLE) || (m == `SMCG_MODE_ADCNR) ||
                      (m == `SMCG_MODE_PDOWN) || (m == `SMCG_MODE_PSAVE) ||
                      (m == `SMCG_MODE_STBY) || (m == `SMCG_MODE_XSTBY);
        end
    endfunction

    // ****************************************
    // pin reset filter
    // ****************************************
    smcg_rst_filt #(
        .MIN_CYC (MIN_CYC),
        .CNT_W   (16)
    ) u_rst_filt (
        .clk       (clk),
        .rstn      (rstn),
        .ext_rstn  (ext_rstn),
        .ext_rst_r (ext_rst)
    );

    // wake source comes from asynchronous peripherals, synchronise it
    // the first stage is read only by the second, so a metastable
    // sample has a whole cycle to settle before the state machine
    // acts on it; this costs two cycles of wake latency
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wake_s1_r <= 1'b0;
            wake_s2_r <= 1'b0;
        end else begin
            wake_s1_r <= wake_irq;
            wake_s2_r <= wake_s1_r;
        end
    end

    // ****************************************
    // sleep state machine
    // ****************************************
    // next state; a refused request (sleep not allowed, reserved code
    // or state_r not ST_RUN) leaves no trace, the cpu simply carries on
    // a wake seen while running is ignored, it only matters asleep
    // the wake state always lasts exactly one cycle
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (sleep_req && sleep_en && mode_ok(sleep_mode)) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_s2_r) begin
                    state_nxt = ST_WAKE;
                end
            end
            ST_WAKE: begin
                state_nxt = ST_RUN;
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // state, mode and enables; pin reset returns everything to run
    // the pin reset keeps the latched mode so it can still be read
    // after restart; sys_rst_r drops one cycle after the last source
    // clears, which gives the rest of the chip one clean edge of reset
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r   <= ST_RUN;
            mode_r    <= `SMCG_MODE_IDLE;
            clk_en_r  <= `SMCG_EN_ALL;
            cpu_run_r <= 1'b0;
            asleep_r  <= 1'b0;
            sys_rst_r <= 1'b1;
        end else if (ext_rst) begin
            state_r   <= ST_RUN;
            clk_en_r  <= `SMCG_EN_ALL;
            cpu_run_r <= 1'b0;
            asleep_r  <= 1'b0;
            sys_rst_r <= 1'b1;
        end else begin
            state_r   <= state_nxt;
            sys_rst_r <= 1'b0;
            case (state_nxt)
                ST_SLEEP: begin
                    if (state_r == ST_RUN) begin
                        mode_r   <= sleep_mode;
                        clk_en_r <= mode_en(sleep_mode);
                    end
                    cpu_run_r <= 1'b0;
                    asleep_r  <= 1'b1;
                end
                ST_WAKE: begin
                    clk_en_r  <= `SMCG_EN_ALL; // clocks first
                    cpu_run_r <= 1'b0;
                    asleep_r  <= 1'b0;
                end
                default: begin
                    clk_en_r  <= `SMCG_EN_ALL;
                    cpu_run_r <= 1'b1;
                    asleep_r  <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // port output enables
    // ****************************************
    // async clear works with no clock; pin reset clears too
    // port_oe_req comes from logic that is itself held in reset, so it
    // is not trusted while sys_rst_r is high; pins stay released until
    // the cycle after the chip leaves reset
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            port_oe_r <= {PORT_W{1'b0}};
        end else if (ext_rst || sys_rst_r) begin
            port_oe_r <= {PORT_W{1'b0}};
        end else begin
            port_oe_r <= port_oe_req;
        end
    end
endmodule // smcg_top
`default_nettype wire

// ---- smcg_consts.vh ----
// constants for the sleep mode clock gating block
`ifndef SMCG_CONSTS_VH
`define SMCG_CONSTS_VH
// ****************************************
// sleep mode encodings
// ****************************************
`define SMCG_MODE_W        3
`define SMCG_MODE_IDLE     3'h0
`define SMCG_MODE_ADCNR    3'h1
`define SMCG_MODE_PDOWN    3'h2
`define SMCG_MODE_PSAVE    3'h3
`define SMCG_MODE_STBY     3'h6
`define SMCG_MODE_XSTBY    3'h7
// ****************************************
// enable vector bit positions
// ****************************************
`define SMCG_EN_W          8
`define SMCG_EN_CPU        0
`define SMCG_EN_SRAM       1
`define SMCG_EN_TMR        2
`define SMCG_EN_SPI        3
`define SMCG_EN_IRQ        4
`define SMCG_EN_ATMR       5
`define SMCG_EN_ADC        6
`define SMCG_EN_OSC        7
`define SMCG_EN_ALL        8'hFF
`define SMCG_EN_NONE       8'h00
// ****************************************
// reset filter and port defaults
// ****************************************
`define SMCG_RST_MIN_NS    2500
`define SMCG_CLK_NS        8
`define SMCG_PORT_W        48
`endif

// ---- smcg_rst_filt.v ----
// external reset pin synchroniser and minimum pulse filter
`timescale 1ns/1ns
`default_nettype none
`include "smcg_consts.vh"

module smcg_rst_filt #(
    parameter integer MIN_CYC = 313,     // cycles a low pin must last
    parameter integer CNT_W   = 16       // counter width
) (
    input  wire             clk,
    input  wire             rstn,
    input  wire             ext_rstn,    // raw reset pin, active low
    output reg              ext_rst_r    // filtered reset request
);
    // ****************************************
    // synchroniser and counter
    // ****************************************
    reg             sync1_r;             // first stage, read only by second
    reg             sync2_r;             // second stage
    reg [CNT_W-1:0] cnt_r;               // low-time counter

    // two-stage synchroniser
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
        end else begin
            sync1_r <= ext_rstn;
            sync2_r <= sync1_r;
        end
    end

    // only a low long enough raises the request
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r     <= {CNT_W{1'b0}};
            ext_rst_r <= 1'b0;
        end else if (sync2_r) begin
            // pin high: short pulses are dropped
            cnt_r     <= {CNT_W{1'b0}};
            ext_rst_r <= 1'b0;
        end else if (cnt_r >= MIN_CYC[CNT_W-1:0] - 1'b1) begin
            ext_rst_r <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule // smcg_rst_filt
`default_nettype wire

// ---- smcg_props.sv ----
// port checker for the sleep mode clock gating block
`timescale 1ns/1ns
`default_nettype none
`include "smcg_consts.vh"
module smcg_props #(
    parameter integer PORT_W  = 48,  // port pins
    parameter integer MIN_CYC = 4    // reset pin filter length
) (
    input wire              clk,
    input wire              rstn,
    input wire              ext_rstn,
    input wire              sleep_en,
    input wire [2:0]        sleep_mode,
    input wire              sleep_req,
    input wire              wake_irq,
    input wire [7:0]        clk_en_r,
    input wire              cpu_run_r,
    input wire              asleep_r,
    input wire [2:0]        mode_r,
    input wire [PORT_W-1:0] port_oe_r,
    input wire              sys_rst_r
);
    // a sleep request that the running block must take if its code is legal
    wire      tk = sleep_req & sleep_en & cpu_run_r & ~asleep_r & ~sys_rst_r;
    reg [7:0] low_r;  // cycles the reset pin has been low
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // saturating count of reset pin low time
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            low_r <= 8'h00;
        else if (ext_rstn)
            low_r <= 8'h00;
        else if (low_r != 8'hFF)
            low_r <= low_r + 8'h01;
    end
    rst_oe_a: assert property (sys_rst_r |-> port_oe_r == 0)
        else $error("port driven in reset");
    long_rst_a: assert property (low_r > MIN_CYC + 4 |-> sys_rst_r)
        else $error("long pin low without reset");
    sleep_take_a: assert property (tk && sleep_mode[2:1] != 2'h2 |=>
        asleep_r && !cpu_run_r && mode_r == $past(sleep_mode))
        else $error("sleep not entered");
    bad_mode_a: assert property (tk && sleep_mode[2:1] == 2'h2 |=> !asleep_r && clk_en_r == 8'hFF)
        else $error("illegal mode taken");
    idle_vec_a: assert property (tk && sleep_mode == 3'h0 |=> clk_en_r == 8'hFE)
        else $error("idle enables wrong");
    adc_vec_a: assert property (tk && sleep_mode == 3'h1 |=> clk_en_r == 8'hF0)
        else $error("adc mode enables wrong");
    pdown_vec_a: assert property (tk && sleep_mode == 3'h2 |=> clk_en_r == 8'h00)
        else $error("power-down enables wrong");
    psave_vec_a: assert property (tk && sleep_mode == 3'h3 |=> clk_en_r == 8'h20)
        else $error("power-save enables wrong");
    stby_vec_a: assert property (tk && sleep_mode == 3'h6 |=> clk_en_r == 8'h80)
        else $error("standby enables wrong");
    xstby_vec_a: assert property (tk && sleep_mode == 3'h7 |=> clk_en_r == 8'hA0)
        else $error("extended standby enables wrong");
    stay_asleep_a: assert property ((asleep_r && !wake_irq) [*3] |=> asleep_r)
        else $error("woke with no interrupt");
    wake_order_a: assert property ($fell(asleep_r) && !sys_rst_r |->
        clk_en_r == 8'hFF && !cpu_run_r ##1 cpu_run_r)
        else $error("cpu resumed before clocks");
endmodule // smcg_props
bind smcg_top smcg_props #(.PORT_W(PORT_W), .MIN_CYC(MIN_CYC)) u_props (.clk(clk), .rstn(rstn), .ext_rstn(ext_rstn),
    .sleep_en(sleep_en), .sleep_mode(sleep_mode), .sleep_req(sleep_req), .wake_irq(wake_irq), .clk_en_r(clk_en_r),
    .cpu_run_r(cpu_run_r), .asleep_r(asleep_r), .mode_r(mode_r), .port_oe_r(port_oe_r), .sys_rst_r(sys_rst_r));
`default_nettype wire

// ---- sleep_mode_clock_gating_test.sv ----
// randomised self-checking bench for the sleep mode clock gating block
`timescale 1ns/1ns
`default_nettype none
`include "smcg_consts.vh"
module sleep_mode_clock_gating_test;
    reg         clk = 1'b0;
    reg         rstn = 1'b0;
    reg         ext_rstn = 1'b1;
    reg         sleep_en = 1'b0;
    reg  [2:0]  sleep_mode = 3'h0;
    reg         sleep_req = 1'b0;
    reg         wake_irq = 1'b0;
    reg  [47:0] port_oe_req = 48'h0;
    wire [7:0]  clk_en_r;
    wire        cpu_run_r;
    wire        asleep_r;
    wire [2:0]  mode_r;
    wire [47:0] port_oe_r;
    wire        sys_rst_r;
    integer     seed = 80234;
    integer     bad_count = 0;
    integer     check_count = 0;
    integer     i, k, n;
    reg  [7:0]  ev;  // expected enables, FF when refused
    smcg_top #(.MIN_CYC(4)) u_dut (.clk(clk), .rstn(rstn), .ext_rstn(ext_rstn), .sleep_en(sleep_en),
        .sleep_mode(sleep_mode), .sleep_req(sleep_req), .wake_irq(wake_irq), .port_oe_req(port_oe_req),
        .clk_en_r(clk_en_r), .cpu_run_r(cpu_run_r), .asleep_r(asleep_r), .mode_r(mode_r),
        .port_oe_r(port_oe_r), .sys_rst_r(sys_rst_r));
    initial forever #4 clk = ~clk;
    // enables each mode leaves running
    function [7:0] vec(input [2:0] m);
        case (m)
            3'h0: vec = 8'hFE;
            3'h1: vec = 8'hF0;
            3'h2: vec = 8'h00;
            3'h3: vec = 8'h20;
            3'h6: vec = 8'h80;
            3'h7: vec = 8'hA0;
            default: vec = 8'hFF;
        endcase
    endfunction
    task chk(input string nm, input [47:0] exp, input [47:0] got);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("FAIL %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", check_count, bad_count);
            if (bad_count == 0 && check_count > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // a wait that ran out of cycles
    task stall;
        begin
            bad_count = bad_count + 1;
            $display("FAIL wait expected done seen stuck");
            summarize;
        end
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        // every code first, then random codes and enables
        for (i = 0; i < 40; i = i + 1) begin
            n = $random(seed);
            sleep_mode <= (i < 8) ? i[2:0] : n[2:0];
            sleep_en <= (i < 8) || (n[5:4] != 2'h0);
            k = $random(seed);
            port_oe_req <= {n[31:16], k};
            sleep_req <= 1'b1;
            @(posedge clk);
            sleep_req <= 1'b0;
            #1 ev = sleep_en ? vec(sleep_mode) : 8'hFF;
            chk("clk_en", ev, clk_en_r);
            chk("asleep", ev != 8'hFF, asleep_r);
            if (ev != 8'hFF) begin
                repeat (n[9:8] + 2) @(posedge clk);
                #1 chk("still_asleep", 1, asleep_r);
                chk("mode", sleep_mode, mode_r);
                @(posedge clk) wake_irq <= 1'b1;
                for (k = 0; k < 8 && asleep_r; k = k + 1) @(posedge clk) #1;
                if (asleep_r)
                    stall;
                chk("wake_en", 8'hFF, clk_en_r);
                chk("wake_cpu", 0, cpu_run_r);
                @(posedge clk) wake_irq <= 1'b0;
                #1 chk("run_cpu", 1, cpu_run_r);
            end
            repeat (3) @(posedge clk);
            chk("port_oe", port_oe_req, port_oe_r);
        end
        // reset raised at an edge clears the port drivers before the next edge
        @(posedge clk) rstn <= 1'b0;
        #1 chk("oe_async", 0, port_oe_r);
        chk("rst_async", 1, sys_rst_r);
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        chk("cpu_after_rst", 1, cpu_run_r);
        chk("rst_released", 0, sys_rst_r);
        // short pin pulse ignored, long one resets
        ext_rstn <= 1'b0;
        repeat (2) @(posedge clk);
        ext_rstn <= 1'b1;
        repeat (6) @(posedge clk);
        #1 chk("short_pulse", 0, sys_rst_r);
        @(posedge clk) ext_rstn <= 1'b0;
        repeat (12) @(posedge clk);
        #1 chk("long_pulse", 1, sys_rst_r);
        chk("oe_pin_rst", 0, port_oe_r);
        @(posedge clk) ext_rstn <= 1'b1;
        for (k = 0; k < 12 && sys_rst_r; k = k + 1) @(posedge clk) #1;
        if (sys_rst_r)
            stall;
        else
            summarize;
    end
endmodule // sleep_mode_clock_gating_test
`default_nettype wire
